// *** design/ccppw_pkg.sv ***
// shared constants, register map and types of the compare/pwm unit
package ccppw_pkg;

  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_DUTY_LO  = 8'h04;
  localparam logic [7:0] OFS_DUTY_SH  = 8'h08;
  localparam logic [7:0] OFS_PERIOD   = 8'h0C;
  localparam logic [7:0] OFS_TCTRL    = 8'h10;
  localparam logic [7:0] OFS_TSEL     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFS_PIN      = 8'h20;
  localparam logic [7:0] OFS_TMR      = 8'h24;

  // ccp_control_reg fields
  localparam int CTRL_W       = 6;
  localparam int CTRL_MODE_HI = 3;
  localparam int CTRL_MODE_LO = 0;
  localparam int CTRL_DLSB_HI = 5;
  localparam int CTRL_DLSB_LO = 4;

  // timer_control_reg fields
  localparam int TCTRL_W     = 3;
  localparam int TCTRL_PS_HI = 1;
  localparam int TCTRL_PS_LO = 0;
  localparam int TCTRL_ON    = 2;

  // pin register fields
  localparam int PIN_DIR   = 0;
  localparam int PIN_LATCH = 1;
  localparam int PIN_LEVEL = 2;

  // reset values
  localparam logic [7:0] PERIOD_RST = 8'hFF;
  localparam logic       PIN_DIR_RST = 1'b1;

  // mode select codes
  localparam logic [3:0] MODE_OFF    = 4'h0;
  localparam logic [3:0] MODE_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_SET    = 4'h8;
  localparam logic [3:0] MODE_CLR    = 4'h9;
  localparam logic [3:0] MODE_SWINT  = 4'hA;
  localparam logic [3:0] MODE_TRIG   = 4'hB;
  localparam logic [1:0] MODE_PWM_HI = 2'h3;

  // timer select codes
  localparam logic [1:0] TSEL_A_T2 = 2'h0;
  localparam logic [1:0] TSEL_B_T4 = 2'h1;
  localparam logic [1:0] TSEL_B_T6 = 2'h2;
  localparam logic [1:0] TSEL_RSVD = 2'h3;

  // prescale codes and terminal counts of the 6-bit phase counter
  localparam logic [1:0] PS_R1   = 2'h0;
  localparam logic [1:0] PS_R4   = 2'h1;
  localparam logic [5:0] TERM_R1 = 6'h03;
  localparam logic [5:0] TERM_R4 = 6'h0F;
  localparam logic [5:0] TERM_R16 = 6'h3F;

  typedef enum logic [2:0] {
    MD_IDLE, MD_TOGGLE, MD_SET, MD_CLEAR, MD_SWINT, MD_TRIG, MD_PWM
  } ccppw_mode_e;

  typedef struct packed {
    logic [15:0] count;
    logic        async_mode;
  } ccppw_tmr_s;

endpackage : ccppw_pkg

// *** design/ccppw_timebase.sv ***
// pwm time base timer: 8-bit count with phase/prescale counter
`timescale 1ns/1ps
`default_nettype none
module ccppw_timebase
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       pce,
  input  wire logic       run,
  input  wire logic [1:0] ps_sel,
  input  wire logic       wrap,
  output logic      [7:0] tmr,
  output logic      [1:0] frac,
  output logic            tick
);
  import ccppw_pkg::*;

  logic [5:0] phase;
  logic [5:0] term;

  always_comb
  begin
    unique case (ps_sel)
      PS_R1:   term = TERM_R1;
      PS_R4:   term = TERM_R4;
      default: term = TERM_R16;
    endcase
  end

  // the two low time base bits split each timer step into four prescaler quarters
  always_comb
  begin
    unique case (ps_sel)
      PS_R1:   frac = phase[1:0];
      PS_R4:   frac = phase[3:2];
      default: frac = phase[5:4];
    endcase
  end

  assign tick = run && (phase == term);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase <= '0;
    else if (pce)
    begin
      if (!run || tick)
        phase <= '0;
      else
        phase <= phase + 6'h01;
    end
  end

  // no postscaler here: period depends on count and prescale only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmr <= '0;
    else if (pce && tick)
      tmr <= wrap ? '0 : tmr + 8'h01;
  end

endmodule : ccppw_timebase
`default_nettype wire

// *** design/ccppw_compare_pwm.sv ***
// compare and pwm unit with its apb register file
`timescale 1ns/1ps
`default_nettype none
module ccppw_compare_pwm
(
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 pce,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire ccppw_pkg::ccppw_tmr_s tmr_a,
  input  wire ccppw_pkg::ccppw_tmr_s tmr_b,
  output logic                      tmr_a_clear,
  output logic                      tmr_b_clear,
  output logic                      special_event,
  output logic                      ccp_pin_o,
  output logic                      ccp_pin_oe_n,
  output logic                      irq
);
  import ccppw_pkg::*;

  logic [CTRL_W-1:0]  ctrl;
  logic [7:0]         duty_low;
  logic [7:0]         duty_shadow;
  logic [1:0]         duty_lat2;
  logic [7:0]         period;
  logic [TCTRL_W-1:0] tctrl;
  logic [1:0]         tsel;
  logic               irq_status;
  logic               irq_mask;
  logic               pin_dir;
  logic               port_latch;
  logic               ccp_latch;
  logic               eq_q;
  ccppw_mode_e        mode;
  logic               wr_en;
  logic               rd_setup;
  logic [31:0]        rd_word;
  logic               sel_a;
  logic               sel_b;
  logic               cmp_mode;
  logic               cmp_ok;
  logic               eq;
  logic               match;
  ccppw_tmr_s         sel_tmr;
  logic [7:0]         tb_tmr;
  logic [1:0]         tb_frac;
  logic               tb_tick;
  logic               pwm_on;
  logic               period_evt;
  logic               period_q;
  logic [9:0]         duty_src;
  logic               duty_hit;
  logic               next_ccp_latch;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = a inside {OFS_CTRL, OFS_DUTY_LO, OFS_DUTY_SH, OFS_PERIOD, OFS_TCTRL,
                          OFS_TSEL, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_PIN, OFS_TMR};
  endfunction : is_mapped

  function automatic logic hits(input logic [7:0] a, input logic [7:0] ofs);
    hits = (a == ofs);
  endfunction : hits

  // apb: zero wait states while enabled, stalled while frozen
  assign pready   = pce;
  assign pslverr  = psel && penable && !is_mapped(paddr);
  assign wr_en    = psel && penable && pwrite && pce && is_mapped(paddr);
  assign rd_setup = psel && !penable && !pwrite;

  always_comb
  begin
    unique case (ctrl[CTRL_MODE_HI:CTRL_MODE_LO])
      MODE_TOGGLE: mode = MD_TOGGLE;
      MODE_SET:    mode = MD_SET;
      MODE_CLR:    mode = MD_CLEAR;
      MODE_SWINT:  mode = MD_SWINT;
      MODE_TRIG:   mode = MD_TRIG;
      default:
      begin
        if (ctrl[CTRL_MODE_HI:CTRL_MODE_HI-1] == MODE_PWM_HI)
          mode = MD_PWM;
        else
          mode = MD_IDLE;
      end
    endcase
  end

  // control register; clearing it is how software resets the output latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= '0;
    else if (pce && wr_en && hits(paddr, OFS_CTRL))
      ctrl <= pwdata[CTRL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      duty_low <= '0;
    else if (pce && wr_en && hits(paddr, OFS_DUTY_LO))
      duty_low <= pwdata[7:0];
  end

  assign duty_src = {duty_low, ctrl[CTRL_DLSB_HI:CTRL_DLSB_LO]};

  // high byte doubles as compare msb and pwm duty buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      duty_shadow <= '0;
      duty_lat2   <= '0;
    end
    else if (pce)
    begin
      if (period_evt)
      begin
        duty_shadow <= duty_src[9:2];
        duty_lat2   <= duty_src[1:0];
      end
      else if (wr_en && hits(paddr, OFS_DUTY_SH) && mode != MD_PWM)
        duty_shadow <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      period <= PERIOD_RST;
    else if (pce && wr_en && hits(paddr, OFS_PERIOD))
      period <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tctrl <= '0;
    else if (pce && wr_en && hits(paddr, OFS_TCTRL))
      tctrl <= pwdata[TCTRL_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tsel <= TSEL_A_T2;
    else if (pce && wr_en && hits(paddr, OFS_TSEL))
      tsel <= pwdata[1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask <= 1'b0;
    else if (pce && wr_en && hits(paddr, OFS_IRQ_MASK))
      irq_mask <= pwdata[0];
  end

  // direction bit high keeps the driver off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_dir    <= PIN_DIR_RST;
      port_latch <= 1'b0;
    end
    else if (pce && wr_en && hits(paddr, OFS_PIN))
    begin
      pin_dir    <= pwdata[PIN_DIR];
      port_latch <= pwdata[PIN_LATCH];
    end
  end

  // compare time base selection
  assign sel_a   = (tsel == TSEL_A_T2);
  assign sel_b   = (tsel == TSEL_B_T4) || (tsel == TSEL_B_T6);
  assign sel_tmr = sel_a ? tmr_a : tmr_b;

  assign cmp_mode = (mode == MD_TOGGLE) || (mode == MD_SET) || (mode == MD_CLEAR)
                 || (mode == MD_SWINT) || (mode == MD_TRIG);
  // async counters can't be compared safely on this clock
  assign cmp_ok = cmp_mode && (sel_a || sel_b) && !sel_tmr.async_mode;
  assign eq     = cmp_ok && (sel_tmr.count == {duty_shadow, duty_low});

  // one event per match even while a slow timer dwells on the value
  assign match = eq && !eq_q;

  // pin is set one cycle after the wrap, so high time is exactly the duty steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      eq_q     <= 1'b0;
      period_q <= 1'b0;
    end
    else if (pce)
    begin
      eq_q     <= eq;
      period_q <= period_evt;
    end
  end

  // trigger pulses to the timer pair; no conversion start output exists
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      special_event <= 1'b0;
      tmr_a_clear   <= 1'b0;
      tmr_b_clear   <= 1'b0;
    end
    else if (pce)
    begin
      special_event <= match && (mode == MD_TRIG);
      tmr_a_clear   <= match && (mode == MD_TRIG) && sel_a;
      tmr_b_clear   <= match && (mode == MD_TRIG) && sel_b;
    end
  end

  // pwm time base; selection code 11 leaves pwm stopped
  assign pwm_on = (mode == MD_PWM) && (tsel != TSEL_RSVD);

  ccppw_timebase u_timebase
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pce     (pce),
    .run     (tctrl[TCTRL_ON]),
    .ps_sel  (tctrl[TCTRL_PS_HI:TCTRL_PS_LO]),
    .wrap    (tb_tmr == period),
    .tmr     (tb_tmr),
    .frac    (tb_frac),
    .tick    (tb_tick)
  );

  // wraps outside pwm mode must not disturb the compare msb
  assign period_evt = pwm_on && tb_tick && (tb_tmr == period);
  // duty above period never matches, so the pin stays high
  assign duty_hit = ({duty_shadow, duty_lat2} == {tb_tmr, tb_frac});

  always_comb
  begin
    next_ccp_latch = ccp_latch;
    unique case (mode)
      MD_TOGGLE:
        if (match)
          next_ccp_latch = !ccp_latch;
      MD_SET:
        if (match)
          next_ccp_latch = 1'b1;
      MD_CLEAR:
        if (match)
          next_ccp_latch = 1'b0;
      MD_PWM:
      begin
        if (pwm_on && period_q)
          next_ccp_latch = ({duty_shadow, duty_lat2} != '0);
        else if (pwm_on && duty_hit)
          next_ccp_latch = 1'b0;
      end
      MD_IDLE, MD_SWINT, MD_TRIG:
        next_ccp_latch = ccp_latch;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ccp_latch <= 1'b0;
    else if (pce)
    begin
      if (wr_en && hits(paddr, OFS_CTRL) && pwdata[CTRL_W-1:0] == '0)
        ccp_latch <= 1'b0;
      else
        ccp_latch <= next_ccp_latch;
    end
  end

  // sticky match flag; a new match wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status <= 1'b0;
    else if (pce)
    begin
      if (match)
        irq_status <= 1'b1;
      else if (wr_en && hits(paddr, OFS_IRQ_STAT) && pwdata[0])
        irq_status <= 1'b0;
    end
  end

  assign irq = irq_status && irq_mask;

  // pin driver: unit latch in output modes, port latch otherwise
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ccp_pin_o    <= 1'b0;
      ccp_pin_oe_n <= PIN_DIR_RST;
    end
    else if (pce)
    begin
      ccp_pin_oe_n <= pin_dir;
      if ((mode == MD_TOGGLE) || (mode == MD_SET) || (mode == MD_CLEAR) || pwm_on)
        ccp_pin_o <= next_ccp_latch;
      else
        ccp_pin_o <= port_latch;
    end
  end

  always_comb
  begin
    rd_word = '0;
    unique case (paddr)
      OFS_CTRL:     rd_word[CTRL_W-1:0] = ctrl;
      OFS_DUTY_LO:  rd_word[7:0] = duty_low;
      OFS_DUTY_SH:  rd_word[7:0] = duty_shadow;
      OFS_PERIOD:   rd_word[7:0] = period;
      OFS_TCTRL:    rd_word[TCTRL_W-1:0] = tctrl;
      OFS_TSEL:     rd_word[1:0] = tsel;
      OFS_IRQ_STAT: rd_word[0] = irq_status;
      OFS_IRQ_MASK: rd_word[0] = irq_mask;
      OFS_PIN:      rd_word[PIN_LEVEL:PIN_DIR] = {ccp_pin_o, port_latch, pin_dir};
      OFS_TMR:      rd_word[7:0] = tb_tmr;
      default:      rd_word = '0;
    endcase
  end

  // read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (pce && rd_setup)
      prdata <= rd_word;
  end

endmodule : ccppw_compare_pwm
`default_nettype wire

// *** verif/ccppw_pin_load.sv ***
// external load on the compare/pwm pin
`timescale 1ns/1ps
`default_nettype none
module ccppw_pin_load
(
  input  wire logic pin_o,
  input  wire logic oe_n,
  output logic      level
);
  // a released pin is pulled up by the external resistor
  assign level = oe_n ? 1'b1 : pin_o;
endmodule : ccppw_pin_load
`default_nettype wire

// *** verif/ccppw_compare_pwm_asserts.sv ***
// port-level checker for the compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
module ccppw_sva
(
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  pce,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire ccppw_pkg::ccppw_tmr_s tmr_a,
  input wire ccppw_pkg::ccppw_tmr_s tmr_b,
  input wire logic                  tmr_a_clear,
  input wire logic                  tmr_b_clear,
  input wire logic                  special_event,
  input wire logic                  ccp_pin_o,
  input wire logic                  ccp_pin_oe_n,
  input wire logic                  irq
);
  import ccppw_pkg::*;
  logic [3:0]  md;
  logic [15:0] cv;
  logic [1:0]  ts;
  logic        mk;
  logic        qp;
  logic        wr;
  logic        q;
  logic        hit;
  ccppw_tmr_s  sel;
  // shadow of the writes, so matches are predicted from bus traffic and timer inputs only
  assign wr = psel & penable & pwrite & pce;
  assign sel = (ts == TSEL_A_T2) ? tmr_a : tmr_b;
  assign q = (md inside {MODE_TOGGLE, MODE_SET, MODE_CLR, MODE_SWINT, MODE_TRIG})
             && ts != TSEL_RSVD && !sel.async_mode && sel.count == cv;
  assign hit = q && !qp && pce;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      md <= 4'h0;
      cv <= 16'h0000;
      ts <= 2'h0;
      mk <= 1'b0;
    end
    else if (wr)
    begin
      if (paddr == OFS_CTRL) md <= pwdata[3:0];
      if (paddr == OFS_DUTY_LO) cv[7:0] <= pwdata[7:0];
      if (paddr == OFS_DUTY_SH) cv[15:8] <= pwdata[7:0];
      if (paddr == OFS_TSEL) ts <= pwdata[1:0];
      if (paddr == OFS_IRQ_MASK) mk <= pwdata[0];
    end
  // equality held for many cycles counts once
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      qp <= 1'b0;
    else if (pce)
      qp <= q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_set_high: assert property (
    hit && md == MODE_SET |=> ccp_pin_o) else $error("pin not high after set match");
  chk_clr_low: assert property (
    hit && md == MODE_CLR |=> !ccp_pin_o) else $error("pin not low after clear match");
  chk_toggle_flip: assert property (
    hit && md == MODE_TOGGLE |=> ccp_pin_o != $past(ccp_pin_o)) else $error("no toggle");
  chk_swint_keep: assert property (
    hit && md == MODE_SWINT |=> $stable(ccp_pin_o)) else $error("pin moved in sw int");
  chk_trig_pulse: assert property (
    hit && md == MODE_TRIG |=> special_event ##1 !special_event) else $error("bad trigger");
  chk_trig_cause: assert property (
    !(hit && md == MODE_TRIG) |=> !special_event) else $error("trigger without match");
  chk_clear_sel: assert property (
    hit && md == MODE_TRIG && ts == TSEL_A_T2 |=> tmr_a_clear && !tmr_b_clear)
    else $error("wrong timer cleared");
  chk_irq_set: assert property (
    hit && mk |=> irq) else $error("irq missing after match");
  chk_irq_mask: assert property (
    !mk |-> !irq) else $error("irq while masked");
  chk_dir_oe: assert property (
    wr && paddr == OFS_PIN |=> ##1 ccp_pin_oe_n == $past(pwdata[PIN_DIR], 2))
    else $error("enable does not follow direction");
endmodule : ccppw_sva
bind ccppw_compare_pwm ccppw_sva u_sva (.pclk(pclk), .presetn(presetn), .pce(pce),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .tmr_a(tmr_a), .tmr_b(tmr_b), .tmr_a_clear(tmr_a_clear), .tmr_b_clear(tmr_b_clear),
  .special_event(special_event), .ccp_pin_o(ccp_pin_o), .ccp_pin_oe_n(ccp_pin_oe_n),
  .irq(irq));
`default_nettype wire

// *** verif/ccp_compare_pwm_unit_tb.sv ***
// self-checking bench for the compare/pwm unit
`timescale 1ns/1ps
`default_nettype none
module ccp_compare_pwm_unit_tb;
  import ccppw_pkg::*;
  logic        pclk = 1'b0, presetn, pce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, a_clr, b_clr, sev, pin_o, oe_n, irq, lvl;
  ccppw_tmr_s  tmr_a = '0, tmr_b = '0;
  int          mismatches = 0, checked = 0, cyc = 0;
  always #2 pclk = ~pclk;
  ccppw_compare_pwm dut (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tmr_a(tmr_a), .tmr_b(tmr_b), .tmr_a_clear(a_clr),
    .tmr_b_clear(b_clr), .special_event(sev), .ccp_pin_o(pin_o), .ccp_pin_oe_n(oe_n),
    .irq(irq));
  ccppw_pin_load load (.pin_o(pin_o), .oe_n(oe_n), .level(lvl));
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // the whole run needs about 2100 cycles
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  // one cycle of equality on the chosen timer, then sample the response
  task automatic hit(input logic b, input logic [15:0] v);
    @(posedge pclk);
    if (b) tmr_b.count <= v; else tmr_a.count <= v;
    @(posedge pclk);
    if (b) tmr_b.count <= v + 16'h0001; else tmr_a.count <= v + 16'h0001;
    #1;
  endtask : hit
  task automatic t_regs;
    apb(1'b0, OFS_TSEL, 32'h0);
    chk("tsel", 32'h0, rd);
    apb(1'b0, OFS_PIN, 32'h0);
    chk("pin reg", 32'h1, rd & 32'h3);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped err", 32'h1, err);
    chk("unmapped data", 32'h0, rd);
    $display("test regs done");
  endtask : t_regs
  task automatic t_compare;
    logic [3:0] md [5] = '{MODE_SET, MODE_CLR, MODE_TOGGLE, MODE_TOGGLE, MODE_SWINT};
    logic       ex [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    apb(1'b1, OFS_DUTY_SH, 32'h12);
    apb(1'b1, OFS_DUTY_LO, 32'h34);
    apb(1'b1, OFS_PIN, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    foreach (md[i])
    begin
      apb(1'b1, OFS_CTRL, {28'h0, md[i]});
      hit(1'b0, 16'h1234);
      chk("pin", ex[i], lvl);
      chk("irq", 32'h1, irq);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      chk("irq cleared", 32'h0, irq);
    end
    $display("test compare done");
  endtask : t_compare
  task automatic t_trigger;
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_CTRL, {28'h0, MODE_TRIG});
    apb(1'b1, OFS_TSEL, {30'h0, TSEL_B_T4});
    hit(1'b1, 16'h1234);
    chk("clear b", 32'h3, {29'h0, a_clr, b_clr, sev});
    chk("masked irq", 32'h0, irq);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    chk("unmasked irq", 32'h1, irq);
    apb(1'b1, OFS_IRQ_STAT, 32'h1);
    @(posedge pclk);
    tmr_b.async_mode <= 1'b1;
    hit(1'b1, 16'h1234);
    chk("async event", 32'h0, sev);
    @(posedge pclk);
    tmr_b.async_mode <= 1'b0;
    apb(1'b1, OFS_TSEL, {30'h0, TSEL_RSVD});
    hit(1'b1, 16'h1234);
    chk("reserved event", 32'h0, sev);
    apb(1'b1, OFS_TSEL, {30'h0, TSEL_A_T2});
    hit(1'b0, 16'h1234);
    chk("clear a", 32'h5, {29'h0, a_clr, b_clr, sev});
    $display("test trigger done");
  endtask : t_trigger
  task automatic t_zero;
    apb(1'b1, OFS_CTRL, {28'h0, MODE_SET});
    hit(1'b0, 16'h1234);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_CTRL, {28'h0, MODE_TOGGLE});
    hit(1'b0, 16'h1234);
    chk("toggle from cleared", 32'h1, lvl);
    $display("test zero done");
  endtask : t_zero
  // a match seen while the clock enable is low must leave no trace
  task automatic t_freeze;
    @(posedge pclk);
    pce <= 1'b0;
    hit(1'b0, 16'h1234);
    chk("frozen ready", 32'h0, pready);
    chk("frozen toggle", 32'h1, lvl);
    @(posedge pclk);
    pce <= 1'b1;
    apb(1'b0, OFS_PIN, 32'h0);
    chk("thawed pin", 32'h4, rd);
    $display("test freeze done");
  endtask : t_freeze
  task automatic duty(input int per, input int exp);
    int hi;
    hi = 0;
    repeat (3 * per) @(posedge pclk);
    repeat (2 * per)
    begin
      @(posedge pclk);
      #1;
      hi += int'(lvl === 1'b1);
    end
    chk("high cycles", exp, hi);
  endtask : duty
  task automatic t_pwm;
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b1, OFS_PERIOD, 32'h3);
    apb(1'b1, OFS_DUTY_LO, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h20);
    apb(1'b1, OFS_PIN, 32'h0);
    for (int ps = 0; ps < 3; ps++)
    begin
      apb(1'b1, OFS_TCTRL, 32'(4 + ps));
      if (ps == 0) apb(1'b1, OFS_CTRL, 32'h2C);
      duty(16 << 2 * ps, 12 << 2 * ps);
    end
    apb(1'b1, OFS_TCTRL, 32'h4);
    @(posedge lvl);
    apb(1'b1, OFS_DUTY_LO, 32'h2);
    apb(1'b1, OFS_DUTY_SH, 32'h55);
    apb(1'b0, OFS_DUTY_SH, 32'h0);
    chk("shadow held", 32'h1, rd);
    duty(16, 20);
    apb(1'b0, OFS_DUTY_SH, 32'h0);
    chk("shadow loaded", 32'h2, rd);
    apb(1'b1, OFS_DUTY_LO, 32'hFF);
    duty(16, 32);
    apb(1'b1, OFS_DUTY_LO, 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0C);
    duty(16, 0);
    $display("test pwm done");
  endtask : t_pwm
  initial
  begin
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_compare();
    t_trigger();
    t_zero();
    t_freeze();
    t_pwm();
    wrap_up();
  end
endmodule : ccp_compare_pwm_unit_tb
`default_nettype wire
